// [hw/resp_agent_pkg.sv]
// Package of register map, opcodes and bus structures for the responding agent
package resp_agent_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_NEXT_PTR   = 8'h00;
	localparam logic [7:0] OFF_CURR_INSTR = 8'h04;
	localparam logic [7:0] OFF_WR_MATCH   = 8'h08;
	localparam logic [7:0] OFF_CAPT_DATA  = 8'h0C;
	localparam logic [7:0] OFF_RD_MATCH   = 8'h10;
	localparam logic [7:0] OFF_RD_DATA    = 8'h14;
	localparam logic [7:0] OFF_DMA_SEL    = 8'h18;
	localparam logic [7:0] OFF_IRQ_SEL    = 8'h1C;
	localparam logic [7:0] OFF_WAIT_CNT   = 8'h20;
	localparam logic [7:0] OFF_RUN_CTRL   = 8'h24;
	localparam logic [7:0] OFF_PROG_ADDR  = 8'h28;
	localparam logic [7:0] OFF_PROG_DATA  = 8'h2C;

	// ****************************************************************
	// Reset values and sizes
	// ****************************************************************
	localparam logic [7:0]  RST_NEXT_PTR  = 8'h00;
	localparam logic [7:0]  RST_DMA_SEL   = 8'h01;
	localparam logic [7:0]  RST_IRQ_SEL   = 8'h03;
	localparam logic [7:0]  RST_WAIT_CNT  = 8'h01;
	localparam logic [23:0] RST_MATCH     = 24'h00_0000;
	localparam logic [15:0] RST_DATA      = 16'h0000;
	localparam int          PROG_DEPTH    = 256;
	localparam int          DRQ_LINES     = 8;
	localparam int          IRQ_LINES     = 16;
	localparam logic [7:0]  DRQ_ABSENT    = 8'h04;
	localparam logic [15:0] IRQ_PRESENT   = 16'hDEF8;

	// ****************************************************************
	// Operation codes
	// ****************************************************************
	localparam logic [7:0] OP_HALT        = 8'h00;
	localparam logic [7:0] OP_IRQ_SET     = 8'h01;
	localparam logic [7:0] OP_IRQ_CLR     = 8'h02;
	localparam logic [7:0] OP_DMA_SET     = 8'h03;
	localparam logic [7:0] OP_DMA_CLR     = 8'h04;
	localparam logic [7:0] OP_CHK_SET     = 8'h05;
	localparam logic [7:0] OP_CHK_CLR     = 8'h06;
	localparam logic [7:0] OP_ONE_WAIT    = 8'h07;

	typedef enum logic [2:0] {
		CYC_NONE, CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR, CYC_DMA_RD, CYC_DMA_WR
	} cyc_kind_e;

	// Bus side inputs (active low strobes)
	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] sd_in;
		logic        memr_n;
		logic        memw_n;
		logic        ior_n;
		logic        iow_n;
		logic        refresh_n;
		logic [7:0]  dack_n;
	} isa_in_s;

	// Bus side outputs
	typedef struct packed {
		logic [15:0] sd_out;
		logic        sd_oe;
		logic        zero_ws_n;
		logic        zero_ws_oe;
		logic        iochrdy_oe;
		logic        iochck_n;
		logic [15:0] irq;
		logic [7:0]  drq;
	} isa_out_s;

endpackage : resp_agent_pkg

// [hw/resp_agent.sv]
// Programmable responding agent on a 16-bit expansion bus, AHB-Lite register slave
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Program store holds 256 byte-wide operation codes executed in order.
// RULE2: Eight-bit pointer addresses next operation; clears to zero at reset.
// RULE3: Current-instruction register holds executing opcode; software may only read.
// RULE4: Opcodes: halt 00, irq set/clear 01/02, dma 03/04, check 05/06, idle 07.
// RULE5: Acts as target for memory, I/O, DMA read/write and refresh. The code ignores memory and I/O cycles while refresh is low.
// RULE6: Write cycles accepted only when bus address equals write match address.
// RULE7: Accepted write captures SD lines into captured-write-data register.
// RULE8: Read cycles accepted only when bus address equals read match address.
// RULE9: Accepted read drives read-return-data register onto SD lines.
// RULE10: DMA channel select resets to 1; channel 4 never driven.
// RULE11: IRQ line select resets to 3; absent lines never driven.
// RULE12: Zero-wait-state asserted in own cycles only when wait count is zero.
// RULE13: Ready released after one clock for count 0 or 1, else X clocks.
// RULE14: Requests service only via IRQ and DRQ; all timing on bus clock.
// RULE15: Idle operation takes one clock and does nothing else.
// RULE16: Halt stops execution; unprogrammed store holds halt.
// RULE17: Next operation fetched on rising edge unless current is halt.
// RULE18: IRQ and DMA operations drive the selected line active or inactive.
// RULE19: Check operations drive channel check active or inactive, one clock each.
// RULE20: Requester grants DACK before DMA cycles and honours ready extension.
module resp_agent (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// AHB-Lite slave
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	// Expansion bus
	input  wire resp_agent_pkg::isa_in_s     bus_in,
	output resp_agent_pkg::isa_out_s         bus_out
);
	import resp_agent_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0]  prog_q [PROG_DEPTH];
	logic [7:0]  next_instr_pointer_q;
	logic [7:0]  current_instr_q;
	logic        running_q;
	logic [23:0] write_match_address_q;
	logic [15:0] captured_write_data_q;
	logic [23:0] read_match_address_q;
	logic [15:0] read_return_data_q;
	logic [7:0]  dma_channel_select_q;
	logic [7:0]  irq_line_select_q;
	logic [7:0]  wait_cycle_count_q;
	logic [7:0]  prog_addr_q;
	// Request levels kept by the stored program
	logic        irq_lvl_q;
	logic        drq_lvl_q;
	logic        chk_lvl_q;

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	logic        wr_pend_q;
	logic [7:0]  wr_off_q;
	logic        ptr_wr;
	logic        run_wr;
	logic        prog_wr;
	logic        ahb_rd;
	logic        word_xfer;

	// Only whole-word transfers reach the registers
	assign word_xfer = (hsize == 3'h2);
	assign ahb_rd    = hsel && hready && htrans[1] && !hwrite && word_xfer;

	// Write data follows one clock after its address phase
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_off_q  <= 8'h00;
		end else begin
			wr_pend_q <= hsel && hready && htrans[1] && hwrite && word_xfer;
			wr_off_q  <= haddr[7:0];
		end
	end

	assign ptr_wr  = wr_pend_q && (wr_off_q == OFF_NEXT_PTR);
	assign run_wr  = wr_pend_q && (wr_off_q == OFF_RUN_CTRL);
	assign prog_wr = wr_pend_q && (wr_off_q == OFF_PROG_DATA);

	// Zero wait states, always OKAY
	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Launched in the address phase so it stands in the data phase
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (ahb_rd) begin
			if (haddr[7:0] == OFF_NEXT_PTR) begin
				hrdata <= {24'h00_0000, next_instr_pointer_q};
			end else if (haddr[7:0] == OFF_CURR_INSTR) begin
				hrdata <= {24'h00_0000, current_instr_q}; // RULE3
			end else if (haddr[7:0] == OFF_WR_MATCH) begin
				hrdata <= {8'h00, write_match_address_q};
			end else if (haddr[7:0] == OFF_CAPT_DATA) begin
				hrdata <= {16'h0000, captured_write_data_q};
			end else if (haddr[7:0] == OFF_RD_MATCH) begin
				hrdata <= {8'h00, read_match_address_q};
			end else if (haddr[7:0] == OFF_RD_DATA) begin
				hrdata <= {16'h0000, read_return_data_q};
			end else if (haddr[7:0] == OFF_DMA_SEL) begin
				hrdata <= {24'h00_0000, dma_channel_select_q};
			end else if (haddr[7:0] == OFF_IRQ_SEL) begin
				hrdata <= {24'h00_0000, irq_line_select_q};
			end else if (haddr[7:0] == OFF_WAIT_CNT) begin
				hrdata <= {24'h00_0000, wait_cycle_count_q};
			end else if (haddr[7:0] == OFF_RUN_CTRL) begin
				hrdata <= {31'h0000_0000, running_q};
			end else if (haddr[7:0] == OFF_PROG_ADDR) begin
				hrdata <= {24'h00_0000, prog_addr_q};
			end else if (haddr[7:0] == OFF_PROG_DATA) begin
				hrdata <= {24'h00_0000, prog_q[prog_addr_q]};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// Plain configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			write_match_address_q <= RST_MATCH;
			read_match_address_q  <= RST_MATCH;
			read_return_data_q    <= RST_DATA;
			dma_channel_select_q  <= RST_DMA_SEL; // RULE10
			irq_line_select_q     <= RST_IRQ_SEL; // RULE11
			wait_cycle_count_q    <= RST_WAIT_CNT; // RULE13
			prog_addr_q           <= 8'h00;
		end else if (wr_pend_q) begin
			if (wr_off_q == OFF_WR_MATCH) begin
				write_match_address_q <= hwdata[23:0];
			end else if (wr_off_q == OFF_RD_MATCH) begin
				read_match_address_q <= hwdata[23:0];
			end else if (wr_off_q == OFF_RD_DATA) begin
				read_return_data_q <= hwdata[15:0];
			end else if (wr_off_q == OFF_DMA_SEL) begin
				dma_channel_select_q <= hwdata[7:0];
			end else if (wr_off_q == OFF_IRQ_SEL) begin
				irq_line_select_q <= hwdata[7:0];
			end else if (wr_off_q == OFF_WAIT_CNT) begin
				wait_cycle_count_q <= hwdata[7:0];
			end else if (wr_off_q == OFF_PROG_ADDR) begin
				prog_addr_q <= hwdata[7:0];
			end
		end else begin
			prog_addr_q <= prog_addr_q;
		end
	end

	// ****************************************************************
	// Program store
	// ****************************************************************
	// Loaded through the index register, read by the pointer
	genvar gi;
	generate
		for (gi = 0; gi < PROG_DEPTH; gi++) begin : g_prog
			always_ff @(posedge clk) begin
				if (rst) begin
					prog_q[gi] <= OP_HALT; // RULE16
				end else if (prog_wr && (prog_addr_q == 8'(gi))) begin
					prog_q[gi] <= hwdata[7:0]; // RULE1
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	logic       seq_step;
	logic [7:0] fetch_op;

	// A pointer or run-control write pauses the program for that clock, so no step runs twice
	assign seq_step = running_q && !ptr_wr && !run_wr;
	assign fetch_op = prog_q[next_instr_pointer_q];

	// Each fetched opcode executes for exactly one clock
	always_ff @(posedge clk) begin
		if (rst) begin
			next_instr_pointer_q <= RST_NEXT_PTR; // RULE2
			current_instr_q      <= OP_HALT;
			running_q            <= 1'b0;
		end else if (ptr_wr) begin
			next_instr_pointer_q <= hwdata[7:0];
		end else if (run_wr) begin
			running_q <= hwdata[0];
		end else if (running_q) begin
			current_instr_q <= fetch_op; // RULE17
			if (fetch_op == OP_HALT) begin
				running_q <= 1'b0; // RULE16
			end else begin
				next_instr_pointer_q <= next_instr_pointer_q + 8'h01; // RULE2
			end
		end
	end

	// Operation effects; idle and unknown codes change nothing
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_lvl_q <= 1'b0;
			drq_lvl_q <= 1'b0;
			chk_lvl_q <= 1'b0;
		end else if (seq_step) begin
			case (fetch_op) // RULE4
				OP_IRQ_SET: irq_lvl_q <= 1'b1; // RULE18
				OP_IRQ_CLR: irq_lvl_q <= 1'b0; // RULE18
				OP_DMA_SET: drq_lvl_q <= 1'b1; // RULE18
				OP_DMA_CLR: drq_lvl_q <= 1'b0; // RULE18
				OP_CHK_SET: chk_lvl_q <= 1'b1; // RULE19
				OP_CHK_CLR: chk_lvl_q <= 1'b0; // RULE19
				OP_ONE_WAIT: irq_lvl_q <= irq_lvl_q; // RULE15
				default: irq_lvl_q <= irq_lvl_q;
			endcase
		end
	end

	// ****************************************************************
	// Bus input synchronisers
	// ****************************************************************
	isa_in_s in_s1_q;
	isa_in_s in_q;

	// Every bus pin passes two flops; decode lags the pins by two clocks
	always_ff @(posedge clk) begin
		if (rst) begin
			in_s1_q <= '1;
			in_q    <= '1;
		end else begin
			in_s1_q <= bus_in;
			in_q    <= in_s1_q;
		end
	end

	// ****************************************************************
	// Target cycle decode
	// ****************************************************************
	logic      dack_active;
	logic      wr_hit;
	logic      rd_hit;
	cyc_kind_e kind;

	// DMA cycles need our own request up and the selected grant low
	assign dack_active = !in_q.dack_n[dma_channel_select_q[2:0]] && drq_lvl_q; // RULE20
	assign wr_hit = (!in_q.memw_n || (!in_q.iow_n && !dack_active)) &&
		(in_q.addr == write_match_address_q) && in_q.refresh_n; // RULE6
	assign rd_hit = (!in_q.memr_n || (!in_q.ior_n && !dack_active)) &&
		(in_q.addr == read_match_address_q) && in_q.refresh_n; // RULE8

	// DMA: the I/O read strobe reads the agent, the I/O write strobe writes it
	always_comb begin
		kind = CYC_NONE;
		if (dack_active && !in_q.ior_n && (in_q.addr == read_match_address_q)) begin
			kind = CYC_DMA_RD; // RULE5
		end else if (dack_active && !in_q.iow_n && (in_q.addr == write_match_address_q)) begin
			kind = CYC_DMA_WR; // RULE5
		end else if (wr_hit) begin
			kind = in_q.memw_n ? CYC_IO_WR : CYC_MEM_WR;
		end else if (rd_hit) begin
			kind = in_q.memr_n ? CYC_IO_RD : CYC_MEM_RD;
		end
	end

	// ****************************************************************
	// Cycle state and wait generation
	// ****************************************************************
	logic       busy_q;
	logic       is_rd_q;
	logic [7:0] wait_left_q;
	logic       strobe_on;

	assign strobe_on = !in_q.memr_n || !in_q.memw_n || !in_q.ior_n || !in_q.iow_n;

	// Not-ready lasts at least one clock; the cycle ends when all strobes rise
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q      <= 1'b0;
			is_rd_q     <= 1'b0;
			wait_left_q <= 8'h00;
		end else if (!busy_q && kind != CYC_NONE) begin
			busy_q  <= 1'b1;
			is_rd_q <= (kind == CYC_MEM_RD) || (kind == CYC_IO_RD) || (kind == CYC_DMA_RD);
			wait_left_q <= (wait_cycle_count_q < 8'h02) ? 8'h01 : wait_cycle_count_q; // RULE13
		end else if (busy_q) begin
			if (wait_left_q != 8'h00) begin
				wait_left_q <= wait_left_q - 8'h01;
			end
			if (!strobe_on) begin
				busy_q <= 1'b0;
			end
		end
	end

	// A bus capture wins over a register write in the same clock
	always_ff @(posedge clk) begin
		if (rst) begin
			captured_write_data_q <= RST_DATA;
		end else if (!busy_q && (kind == CYC_MEM_WR || kind == CYC_IO_WR ||
			kind == CYC_DMA_WR)) begin
			captured_write_data_q <= in_q.sd_in; // RULE7
		end else if (wr_pend_q && wr_off_q == OFF_CAPT_DATA) begin
			captured_write_data_q <= hwdata[15:0];
		end
	end

	// ****************************************************************
	// Request line select
	// ****************************************************************
	// Absent lines and out-of-range selects decode to no line at all
	logic [IRQ_LINES-1:0] irq_line_d;
	logic [DRQ_LINES-1:0] drq_line_d;

	genvar gl;
	generate
		for (gl = 0; gl < IRQ_LINES; gl++) begin : g_irq_line
			assign irq_line_d[gl] = irq_lvl_q && IRQ_PRESENT[gl] &&
				(irq_line_select_q == 8'(gl)); // RULE11 RULE14
		end
		for (gl = 0; gl < DRQ_LINES; gl++) begin : g_drq_line
			assign drq_line_d[gl] = drq_lvl_q && (8'(gl) != DRQ_ABSENT) &&
				(dma_channel_select_q == 8'(gl)); // RULE10 RULE14
		end
	endgenerate

	// ****************************************************************
	// Bus outputs
	// ****************************************************************
	// Ready and zero-wait follow the decode by two clocks
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_out <= '{sd_out: 16'h0000, sd_oe: 1'b0, zero_ws_n: 1'b1, zero_ws_oe: 1'b0,
				iochrdy_oe: 1'b0, iochck_n: 1'b1, irq: 16'h0000, drq: 8'h00};
		end else begin
			bus_out.sd_out     <= read_return_data_q; // RULE9
			bus_out.sd_oe      <= busy_q && is_rd_q && strobe_on; // RULE9
			bus_out.zero_ws_n  <= 1'b0;
			bus_out.zero_ws_oe <= busy_q && strobe_on && (wait_cycle_count_q == 8'h00); // RULE12
			bus_out.iochrdy_oe <= busy_q && strobe_on && (wait_left_q != 8'h00); // RULE13
			bus_out.iochck_n   <= !chk_lvl_q; // RULE19
			bus_out.irq        <= irq_line_d; // RULE11 RULE14
			bus_out.drq        <= drq_line_d; // RULE10 RULE14
		end
	end

endmodule : resp_agent

`default_nettype wire

// [verification/resp_agent_asserts.sv]
// Port checker for the responding agent
`timescale 1ns/1ps
`default_nettype none
module resp_agent_asserts (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     rst,
	// Expansion bus
	input wire resp_agent_pkg::isa_in_s  bus_in,
	input wire resp_agent_pkg::isa_out_s bus_out
);
	import resp_agent_pkg::*;
	default clocking dclk @(posedge clk);
	endclocking
	default disable iff (rst);

	// ********
	// Strobe decode
	// ********
	logic rd_low;
	logic any_low;
	assign rd_low = (!bus_in.memr_n && bus_in.refresh_n) || !bus_in.ior_n;
	assign any_low = rd_low || !bus_in.memw_n || !bus_in.iow_n;

	// ********
	// Properties
	// ********
	a_drq_no_four: assert property (!bus_out.drq[4])
		else $error("missing dma channel driven");
	a_drq_one_line: assert property ($onehot0(bus_out.drq))
		else $error("more than one dma request line");
	a_irq_absent_lines: assert property ((bus_out.irq & ~IRQ_PRESENT) == 16'h0000)
		else $error("absent interrupt line driven");
	a_irq_one_line: assert property ($onehot0(bus_out.irq))
		else $error("more than one interrupt line");
	a_sd_drive_cause: assert property (bus_out.sd_oe |->
		$past(rd_low, 2) || $past(rd_low, 3) || $past(rd_low, 4))
		else $error("data lines driven without a read");
	a_rdy_cause: assert property ($rose(bus_out.iochrdy_oe) |->
		$past(any_low, 2) || $past(any_low, 3) || $past(any_low, 4))
		else $error("ready held without a cycle");
	a_rdy_bounded: assert property ($rose(bus_out.iochrdy_oe) |->
		##[1:255] !bus_out.iochrdy_oe)
		else $error("ready never released");
	a_zws_own_cycle: assert property (bus_out.zero_ws_oe |->
		$past(any_low, 2) || $past(any_low, 3) || $past(any_low, 4))
		else $error("zero wait outside own cycle");
	a_zws_drive_low: assert property (bus_out.zero_ws_oe |-> !bus_out.zero_ws_n)
		else $error("zero wait driven high");
endmodule : resp_agent_asserts

bind resp_agent resp_agent_asserts chk_u (.clk, .rst, .bus_in, .bus_out);
`default_nettype wire

// [verification/isa_requester.sv]
// Requesting agent model driving the expansion bus
`timescale 1ns/1ps
`default_nettype none
module isa_requester (
	// Clock
	input  wire logic                     clk,
	// Expansion bus
	output var resp_agent_pkg::isa_in_s   bus_in,
	input  wire resp_agent_pkg::isa_out_s bus_out
);
	import resp_agent_pkg::*;
	initial begin
		bus_in = '{24'h00_0000, 16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF};
	end

	// Kind: 0 memr 1 memw 2 ior 3 iow 4 dma rd 5 dma wr 6 refresh
	task automatic xfer(input logic [2:0] k, input logic [23:0] a, input logic [15:0] d,
		input logic [2:0] ch, output logic acc, output int nrdy, output logic zws,
		output logic [15:0] q);
		acc = 1'b0;
		nrdy = 0;
		zws = 1'b0;
		// DACK is granted after the agent raises its DMA request, or after eight clocks without it
		if (k == 4 || k == 5) begin
			for (int w = 0; w < 8 && !bus_out.drq[ch]; w++) begin
				@(posedge clk);
			end
		end
		bus_in.addr <= a;
		bus_in.sd_in <= (k == 1 || k == 3 || k == 5) ? d : ~bus_in.sd_in;
		bus_in.memr_n <= !(k == 0 || k == 6);
		bus_in.memw_n <= (k != 1);
		bus_in.ior_n <= !(k == 2 || k == 4);
		bus_in.iow_n <= !(k == 3 || k == 5);
		bus_in.refresh_n <= (k != 6);
		if (k == 4 || k == 5) bus_in.dack_n[ch] <= 1'b0;
		for (int n = 0; n < 6 && !acc; n++) begin
			@(posedge clk);
			acc = bus_out.iochrdy_oe;
			zws |= bus_out.zero_ws_oe;
		end
		// Hold the strobe while ready is pulled low
		while (acc && bus_out.iochrdy_oe && nrdy < 300) begin
			nrdy++;
			@(posedge clk);
			zws |= bus_out.zero_ws_oe;
		end
		q = bus_out.sd_oe ? bus_out.sd_out : 16'h0000;
		// Released address and data lines show the inverse of their last value
		bus_in <= '{~a, ~bus_in.sd_in, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hFF};
		repeat (2) @(posedge clk);
	endtask : xfer
endmodule : isa_requester
`default_nettype wire

// [verification/resp_agent_tb_top.sv]
// Self-checking testbench for the responding agent
`timescale 1ns/1ps
`default_nettype none
module resp_agent_tb_top;
	import resp_agent_pkg::*;
	logic        clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	isa_in_s     bus_in;
	isa_out_s    bus_out;
	int          bad_count;
	int          num_checks;
	logic        acc;
	logic        zws;
	int          nrdy;
	logic [15:0] q;

	resp_agent dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_in(bus_in),
		.bus_out(bus_out));
	isa_requester req_u (.clk(clk), .bus_in(bus_in), .bus_out(bus_out));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ********
	// Shared tasks
	// ********
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		r = hrdata;
		chk("bus response", 32'h0000_0000, {31'h0000_0000, hresp});
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk(n, e, r);
	endtask : rchk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	// ********
	// Scenarios
	// ********
	task automatic t_regs;
		logic [7:0] o [10] = '{OFF_NEXT_PTR, OFF_CURR_INSTR, OFF_WR_MATCH, OFF_CAPT_DATA,
			OFF_RD_MATCH, OFF_RD_DATA, OFF_DMA_SEL, OFF_IRQ_SEL, OFF_WAIT_CNT, 8'h30};
		logic [7:0] v [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03,
			8'h01, 8'h00};
		foreach (o[i]) rchk(o[i], {24'h00_0000, v[i]}, "reset value");
		wr(OFF_CURR_INSTR, 32'h0000_00FF);
		rchk(OFF_CURR_INSTR, 32'h0000_0000, "current instr");
		wr(OFF_WR_MATCH, 32'hFFFF_FFFF);
		rchk(OFF_WR_MATCH, 32'h00FF_FFFF, "write match");
		wr(OFF_PROG_ADDR, 32'h0000_00FF);
		wr(OFF_PROG_DATA, 32'h0000_0007);
		rchk(OFF_PROG_DATA, 32'h0000_0007, "last program slot");
		$display("test registers done");
	endtask : t_regs

	task automatic t_writes;
		logic [7:0] wt [3] = '{8'h00, 8'h01, 8'h03};
		wr(OFF_WR_MATCH, 32'h000A_1234);
		foreach (wt[i]) begin
			wr(OFF_WAIT_CNT, {24'h00_0000, wt[i]});
			req_u.xfer(i == 1 ? 3'h3 : 3'h1, 24'h0A_1234, {8'h5A, wt[i]}, 3'h0, acc, nrdy, zws, q);
			chk("write accepted", 32'h0000_0001, {31'h0000_0000, acc});
			chk("ready wait", (wt[i] < 2) ? 32'h0000_0001 : {24'h00_0000, wt[i]}, nrdy);
			chk("zero wait", {31'h0000_0000, wt[i] == 8'h00}, {31'h0000_0000, zws});
			rchk(OFF_CAPT_DATA, {16'h0000, 8'h5A, wt[i]}, "captured data");
		end
		req_u.xfer(3'h1, 24'h0A_1235, 16'h1111, 3'h0, acc, nrdy, zws, q);
		chk("mismatch accepted", 32'h0000_0000, {31'h0000_0000, acc});
		rchk(OFF_CAPT_DATA, 32'h0000_5A03, "captured data");
		$display("test writes done");
	endtask : t_writes

	task automatic t_reads;
		logic [2:0]  k [5] = '{3'h0, 3'h2, 3'h0, 3'h6, 3'h1};
		logic [23:0] a [5] = '{24'h00_03F0, 24'h00_03F0, 24'h00_03F1, 24'h00_03F0, 24'h00_03F0};
		wr(OFF_RD_MATCH, 32'h0000_03F0);
		wr(OFF_RD_DATA, 32'h0000_A5C3);
		wr(OFF_WAIT_CNT, 32'h0000_0002);
		foreach (k[i]) begin
			req_u.xfer(k[i], a[i], 16'h2222, 3'h0, acc, nrdy, zws, q);
			chk("read accepted", {31'h0000_0000, i < 2}, {31'h0000_0000, acc});
			chk("read data", (i < 2) ? 32'h0000_A5C3 : 32'h0000_0000, {16'h0000, q});
			chk("ready wait", (i < 2) ? 32'h0000_0002 : 32'h0000_0000, nrdy);
		end
		$display("test reads done");
	endtask : t_reads

	task automatic t_program;
		logic [7:0] op [13] = '{8'h01, 8'h07, 8'h03, 8'h05, 8'h06, 8'h02, 8'h00, 8'h00,
			8'h04, 8'h00, 8'h01, 8'h03, 8'h00};
		logic [2:0] ex [7] = '{3'h5, 3'h5, 3'h7, 3'h6, 3'h7, 3'h3, 3'h3};
		logic [2:0] tr [20];
		int t;
		foreach (op[i]) begin
			wr(OFF_PROG_ADDR, i);
			wr(OFF_PROG_DATA, {24'h00_0000, op[i]});
		end
		wr(OFF_DMA_SEL, 32'h0000_0005);
		wr(OFF_IRQ_SEL, 32'h0000_0009);
		wr(OFF_RUN_CTRL, 32'h0000_0001);
		for (int c = 0; c < 20; c++) begin
			@(posedge clk);
			tr[c] = {bus_out.irq[9], bus_out.drq[5], bus_out.iochck_n};
		end
		t = 0;
		while (t < 13 && tr[t][2] !== 1'b1) t++;
		chk("first effect cycle", 32'h0000_0002, t);
		foreach (ex[j]) chk("sequencer lines", ex[j], tr[t + j]);
		rchk(OFF_NEXT_PTR, 32'h0000_0006, "pointer at halt");
		rchk(OFF_CURR_INSTR, 32'h0000_0000, "current instr");
		req_u.xfer(3'h5, 24'h0A_1234, 16'hC0DE, 3'h5, acc, nrdy, zws, q);
		rchk(OFF_CAPT_DATA, 32'h0000_C0DE, "dma write data");
		req_u.xfer(3'h4, 24'h00_03F0, 16'h0000, 3'h5, acc, nrdy, zws, q);
		chk("dma read data", 32'h0000_A5C3, {16'h0000, q});
		wr(OFF_NEXT_PTR, 32'h0000_0008);
		wr(OFF_RUN_CTRL, 32'h0000_0001);
		repeat (4) @(posedge clk);
		chk("dma request", 32'h0000_0000, {24'h00_0000, bus_out.drq});
		rchk(OFF_NEXT_PTR, 32'h0000_0009, "pointer at halt");
		wr(OFF_DMA_SEL, 32'h0000_0004);
		wr(OFF_IRQ_SEL, 32'h0000_0002);
		wr(OFF_NEXT_PTR, 32'h0000_000A);
		wr(OFF_RUN_CTRL, 32'h0000_0001);
		repeat (5) @(posedge clk);
		chk("missing dma line", 32'h0000_0000, {24'h00_0000, bus_out.drq});
		chk("absent irq line", 32'h0000_0000, {16'h0000, bus_out.irq});
		$display("test program done");
	endtask : t_program

	// ********
	// Main sequence and watchdog
	// ********
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		bad_count = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_writes();
		t_reads();
		t_program();
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk);
		$display("watchdog expired");
		bad_count++;
		end_sim();
	end
endmodule : resp_agent_tb_top
`default_nettype wire
